// File: shared/bias_pkg.sv
// register map, field layouts, reset values and i2c states of the backlight/bias register bank
// assumes an i2c target front end and 8-bit registers
package bias_pkg;
	localparam logic [7:0] OVP_OFS  = 8'h02;
	localparam logic [7:0] BLEN_OFS = 8'h08;
	localparam logic [7:0] BIAS_OFS = 8'h09;
	localparam logic [7:0] FLAG_OFS = 8'h0f;
	localparam logic [7:0] ILIM_OFS = 8'h11;

	localparam logic [7:0] OVP_RST  = 8'h00;
	localparam logic [7:0] BLEN_RST = 8'h00;
	localparam logic [7:0] BIAS_RST = 8'h18;
	localparam logic [7:0] FLAG_RST = 8'h00;
	localparam logic [7:0] ILIM_RST = 8'h35;

	// field positions
	localparam int OVP_LSB      = 5;
	localparam int OVP_W        = 3;
	localparam int IND_LSB      = 5;
	localparam int IND_W        = 2;
	localparam int OCP_LSB      = 0;
	localparam int OCP_W        = 2;
	localparam int MODE_W       = 3;
	localparam int STRINGS      = 4;

	// fault and flag bit positions
	localparam int FLG_THERMAL  = 7;
	localparam int FLG_DISPLAY_OVERVOLTAGE_FLAG = 6;
	localparam int FLG_POSITIVE_RAIL_SHORT_FLAG = 5;
	localparam int FLG_VN_SHORT = 4;
	localparam int FLG_BACKLIGHT_OVERCURRENT_LIMIT   = 3;
	localparam int FLG_BACKLIGHT_OVERVOLTAGE_LEVEL   = 2;

	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic [6:0] DEV_ADDR_DEF  = 7'h11;

	typedef struct packed {
		logic                       sw_reset;
		logic [1:0]                 unused;
		logic                       master;
		logic [STRINGS-1:0]         strings;
	} backlight_master_enable_s;

	typedef struct packed {
		logic [MODE_W-1:0] mode;
		logic              pos_disch;
		logic              neg_disch;
		logic              pos_en;
		logic              neg_en;
		logic              ext_sel;
	} bias_cfg_s;

	typedef enum logic [8:0] {
		ST_IDLE = 9'b000000001,
		ST_ADDR = 9'b000000010,
		ST_AACK = 9'b000000100,
		ST_PTR  = 9'b000001000,
		ST_PACK = 9'b000010000,
		ST_WR   = 9'b000100000,
		ST_WACK = 9'b001000000,
		ST_RD   = 9'b010000000,
		ST_RACK = 9'b100000000
	} i2c_state_e;
endpackage

// File: rtl/flag_capture.sv
// sticky fault/flag register that clears when read
// assumes one-cycle event pulses and a one-cycle read-clear strobe
`timescale 1ns/1ns
module flag_capture
	import bias_pkg::*;
#(
	parameter int W = 8
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic [W-1:0] events,
	input  wire logic         rd_clear,
	input  wire logic         soft_clear,
	output logic      [W-1:0] flags
);
	logic [W-1:0] flags_q;
	logic [W-1:0] flags_d;

	// an event in the clearing cycle survives
	always_comb begin
		flags_d = flags_q;
		if (rd_clear || soft_clear) begin
			flags_d = '0;
		end
		flags_d = flags_d | events;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			flags_q <= FLAG_RST[W-1:0];
		end else begin
			flags_q <= flags_d;
		end
	end

	assign flags = flags_q;
endmodule

// File: rtl/bias_regs_top.sv
// i2c target register bank of a backlight driver with display bias rails
// assumes SCL/SDA already synchronous to CLK; SDA is open drain, resolved outside
`timescale 1ns/1ns
module bias_regs_top
	import bias_pkg::*;
#(
	parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEF
) (
	input  wire logic                  CLK,
	input  wire logic                  SYS_RST,
	input  wire logic                  SCL_I,
	input  wire logic                  SDA_I,
	output logic                       SDA_O,
	output logic                       SDA_OE,
	input  wire logic                  POS_RAIL_ENABLE_PIN,
	input  wire logic                  NEG_RAIL_ENABLE_PIN,
	input  wire logic [7:0]            FAULT_EVENTS,
	output logic [STRINGS-1:0]         LED_STRING_ON,
	output logic                       POSITIVE_BIAS_OUTPUT,
	output logic                       NEGATIVE_BIAS_OUTPUT,
	output logic                       POS_RAIL_DISCHARGE,
	output logic                       NEG_RAIL_DISCHARGE,
	output logic [MODE_W-1:0]          BIAS_OPERATING_MODE,
	output logic [OVP_W-1:0]           BACKLIGHT_OVERVOLTAGE_LEVEL,
	output logic [OCP_W-1:0]           BACKLIGHT_OVERCURRENT_LIMIT,
	output logic [IND_W-1:0]           INDUCTOR_RANGE_SELECT
);
	import bias_pkg::*;

	// pin sampling
	logic scl_q, sda_q, scl_p, sda_p;
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			scl_p <= 1'b1;
			sda_p <= 1'b1;
		end else begin
			scl_q <= SCL_I;
			sda_q <= SDA_I;
			scl_p <= scl_q;
			sda_p <= sda_q;
		end
	end
	logic scl_rise, scl_fall, start_c, stop_c;
	assign scl_rise = scl_q & ~scl_p;
	assign scl_fall = ~scl_q & scl_p;
	assign start_c  = scl_q & scl_p & sda_p & ~sda_q;
	assign stop_c   = scl_q & scl_p & ~sda_p & sda_q;

	// register storage
	logic [7:0] ovp_q, ovp_d, ilim_q, ilim_d;
	backlight_master_enable_s     blen_q, blen_d;
	bias_cfg_s  bias_q, bias_d;
	logic [7:0] flags;

	// i2c engine state
	i2c_state_e st_q, st_d;
	logic [3:0] cnt_q, cnt_d;
	logic [7:0] sh_q, sh_d, tx_q, tx_d, ptr_q, ptr_d;
	logic       oe_q, oe_d, rw_q, rw_d, ack_q, ack_d;
	logic       wr_stb, rd_clr;
	logic [7:0] wr_addr, rd_data;

	always_comb begin
		case (ptr_q)
			OVP_OFS:  rd_data = ovp_q;
			BLEN_OFS: rd_data = blen_q;
			BIAS_OFS: rd_data = bias_q;
			FLAG_OFS: rd_data = flags;
			ILIM_OFS: rd_data = ilim_q;
			default:  rd_data = 8'h00;
		endcase
	end

	always_comb begin
		st_d    = st_q;
		cnt_d   = cnt_q;
		sh_d    = sh_q;
		tx_d    = tx_q;
		ptr_d   = ptr_q;
		oe_d    = oe_q;
		rw_d    = rw_q;
		ack_d   = ack_q;
		wr_stb  = 1'b0;
		wr_addr = ptr_q;
		rd_clr  = 1'b0;
		if (start_c) begin
			st_d  = ST_ADDR;
			cnt_d = 4'h0;
			oe_d  = 1'b0;
		end else if (stop_c) begin
			st_d = ST_IDLE;
			oe_d = 1'b0;
		end else begin
			case (st_q)
				ST_IDLE: begin
					oe_d = 1'b0;
				end
				ST_ADDR, ST_PTR, ST_WR: begin
					if (scl_rise) begin
						sh_d  = {sh_q[6:0], sda_q};
						cnt_d = cnt_q + 4'h1;
					end else if (scl_fall && cnt_q == BITS_PER_BYTE) begin
						cnt_d = 4'h0;
						if (st_q == ST_ADDR) begin
							if (sh_q[7:1] == DEV_ADDR) begin
								rw_d = sh_q[0];
								oe_d = 1'b1;
								st_d = ST_AACK;
							end else begin
								st_d = ST_IDLE;
							end
						end else if (st_q == ST_PTR) begin
							ptr_d = sh_q;
							oe_d  = 1'b1;
							st_d  = ST_PACK;
						end else begin
							wr_stb = 1'b1;
							ptr_d  = ptr_q + 8'h01;
							oe_d   = 1'b1;
							st_d   = ST_WACK;
						end
					end
				end
				ST_AACK, ST_PACK, ST_WACK: begin
					if (scl_fall) begin
						oe_d  = 1'b0;
						cnt_d = 4'h0;
						if (st_q == ST_AACK && rw_q) begin
							tx_d   = rd_data;
							oe_d   = ~rd_data[7];
							rd_clr = (ptr_q == FLAG_OFS);
							ptr_d  = ptr_q + 8'h01;
							cnt_d  = 4'h1;
							st_d   = ST_RD;
						end else if (st_q == ST_AACK) begin
							st_d = ST_PTR;
						end else begin
							st_d = ST_WR;
						end
					end
				end
				ST_RD: begin
					if (scl_fall) begin
						if (cnt_q == BITS_PER_BYTE) begin
							oe_d = 1'b0;
							st_d = ST_RACK;
						end else begin
							oe_d  = ~tx_q[6];
							tx_d  = {tx_q[6:0], 1'b0};
							cnt_d = cnt_q + 4'h1;
						end
					end
				end
				ST_RACK: begin
					if (scl_rise) begin
						ack_d = ~sda_q;
					end else if (scl_fall) begin
						if (ack_q) begin
							tx_d   = rd_data;
							oe_d   = ~rd_data[7];
							rd_clr = (ptr_q == FLAG_OFS);
							ptr_d  = ptr_q + 8'h01;
							cnt_d  = 4'h1;
							st_d   = ST_RD;
						end else begin
							st_d = ST_IDLE;
						end
					end
				end
				default: begin
					st_d = ST_IDLE;
					oe_d = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			st_q  <= ST_IDLE;
			cnt_q <= 4'h0;
			sh_q  <= 8'h00;
			tx_q  <= 8'h00;
			ptr_q <= 8'h00;
			oe_q  <= 1'b0;
			rw_q  <= 1'b0;
			ack_q <= 1'b0;
		end else begin
			st_q  <= st_d;
			cnt_q <= cnt_d;
			sh_q  <= sh_d;
			tx_q  <= tx_d;
			ptr_q <= ptr_d;
			oe_q  <= oe_d;
			rw_q  <= rw_d;
			ack_q <= ack_d;
		end
	end

	// register writes and software restore
	logic soft_rst;
	assign soft_rst = blen_q.sw_reset;

	always_comb begin
		ovp_d  = ovp_q;
		blen_d = blen_q;
		bias_d = bias_q;
		ilim_d = ilim_q;
		if (soft_rst) begin
			ovp_d  = OVP_RST;
			blen_d = BLEN_RST;
			bias_d = BIAS_RST;
			ilim_d = ILIM_RST;
		end else if (wr_stb) begin
			case (wr_addr)
				OVP_OFS:  ovp_d = sh_q;
				BLEN_OFS: blen_d = sh_q;
				BIAS_OFS: bias_d = sh_q;
				ILIM_OFS: ilim_d = sh_q;
				default:  ovp_d = ovp_q;
			endcase
		end
	end

	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			ovp_q  <= OVP_RST;
			blen_q <= BLEN_RST;
			bias_q <= BIAS_RST;
			ilim_q <= ILIM_RST;
		end else begin
			ovp_q  <= ovp_d;
			blen_q <= blen_d;
			bias_q <= bias_d;
			ilim_q <= ilim_d;
		end
	end

	flag_capture #(
		.W (8)
	) u_flags (
		.clk        (CLK),
		.rst        (SYS_RST),
		.events     (FAULT_EVENTS),
		.rd_clear   (rd_clr),
		.soft_clear (soft_rst),
		.flags      (flags)
	);

	// output block control
	logic                bl_fault, bias_fault, pos_req, neg_req, bias_on;
	logic [STRINGS-1:0]  led_q, led_d;
	logic                pos_q, pos_d, neg_q, neg_d;
	logic                pdis_q, ndis_q;
	logic [MODE_W-1:0]   mode_q;
	logic [OVP_W-1:0]    ovpl_q;
	logic [OCP_W-1:0]    ocp_q;
	logic [IND_W-1:0]    ind_q;

	assign bl_fault   = flags[FLG_THERMAL] | flags[FLG_BACKLIGHT_OVERCURRENT_LIMIT] | flags[FLG_BACKLIGHT_OVERVOLTAGE_LEVEL];
	assign bias_fault = flags[FLG_THERMAL] | flags[FLG_POSITIVE_RAIL_SHORT_FLAG] | flags[FLG_VN_SHORT];
	assign bias_on    = (bias_q.mode != '0);
	assign pos_req    = bias_on & (bias_q.ext_sel ? POS_RAIL_ENABLE_PIN : bias_q.pos_en);
	assign neg_req    = bias_on & (bias_q.ext_sel ? NEG_RAIL_ENABLE_PIN : bias_q.neg_en);

	// a block already on stays on; a fault only stops a new turn-on
	always_comb begin
		led_d = blen_q.strings & {STRINGS{blen_q.master}} & (led_q | {STRINGS{~bl_fault}});
		pos_d = pos_req & (pos_q | ~bias_fault);
		neg_d = neg_req & (neg_q | ~bias_fault);
	end

	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			led_q  <= '0;
			pos_q  <= 1'b0;
			neg_q  <= 1'b0;
			pdis_q <= 1'b0;
			ndis_q <= 1'b0;
			mode_q <= '0;
			ovpl_q <= '0;
			ocp_q  <= '0;
			ind_q  <= '0;
		end else begin
			led_q  <= led_d;
			pos_q  <= pos_d;
			neg_q  <= neg_d;
			pdis_q <= bias_q.pos_disch;
			ndis_q <= bias_q.neg_disch;
			mode_q <= bias_q.mode;
			ovpl_q <= ovp_q[OVP_LSB +: OVP_W];
			ocp_q  <= ilim_q[OCP_LSB +: OCP_W];
			ind_q  <= ilim_q[IND_LSB +: IND_W];
		end
	end

	assign SDA_O                       = 1'b0;
	assign SDA_OE                      = oe_q;
	assign LED_STRING_ON               = led_q;
	assign POSITIVE_BIAS_OUTPUT        = pos_q;
	assign NEGATIVE_BIAS_OUTPUT        = neg_q;
	assign POS_RAIL_DISCHARGE          = pdis_q;
	assign NEG_RAIL_DISCHARGE          = ndis_q;
	assign BIAS_OPERATING_MODE         = mode_q;
	assign BACKLIGHT_OVERVOLTAGE_LEVEL = ovpl_q;
	assign BACKLIGHT_OVERCURRENT_LIMIT = ocp_q;
	assign INDUCTOR_RANGE_SELECT       = ind_q;
endmodule

// File: verification/bias_port_monitor.sv
// port assertions for the backlight/bias register bank
// assumes it is bound onto bias_regs_top and sees only its ports
`timescale 1ns/1ns
module bias_port_chk (
	input wire logic       CLK,
	input wire logic       SYS_RST,
	input wire logic       SCL_I,
	input wire logic       SDA_OE,
	input wire logic [7:0] FAULT_EVENTS,
	input wire logic [3:0] LED_STRING_ON,
	input wire logic       POSITIVE_BIAS_OUTPUT,
	input wire logic       NEGATIVE_BIAS_OUTPUT,
	input wire logic       POS_RAIL_DISCHARGE,
	input wire logic       NEG_RAIL_DISCHARGE,
	input wire logic [2:0] BIAS_OPERATING_MODE,
	input wire logic [2:0] BACKLIGHT_OVERVOLTAGE_LEVEL,
	input wire logic [1:0] BACKLIGHT_OVERCURRENT_LIMIT,
	input wire logic [1:0] INDUCTOR_RANGE_SELECT
);
	import bias_pkg::*;
	default clocking @(posedge CLK); endclocking
	default disable iff (SYS_RST);
	a_reset_defaults:
		assert property ($fell(SYS_RST) |-> !SDA_OE && LED_STRING_ON == 4'h0 ##1 POS_RAIL_DISCHARGE
			&& NEG_RAIL_DISCHARGE && INDUCTOR_RANGE_SELECT == ILIM_RST[IND_LSB +: IND_W]) else $error("bad reset state");
	a_oe_after_fall:
		assert property ($changed(SDA_OE) |-> !SCL_I && !$past(SCL_I, 2) && $past(SCL_I, 6)) else $error("sda moved late");
	a_rail_mode_off:
		assert property (POSITIVE_BIAS_OUTPUT || NEGATIVE_BIAS_OUTPUT |-> BIAS_OPERATING_MODE != 3'h0) else $error("rail on, mode off");
	a_string_fault_block:
		assert property ((LED_STRING_ON & ~$past(LED_STRING_ON)) != 4'h0 |-> !$past(|(FAULT_EVENTS & 8'h8c), 2))
			else $error("string on after fault");
	a_rail_fault_block:
		assert property ($rose(POSITIVE_BIAS_OUTPUT) || $rose(NEGATIVE_BIAS_OUTPUT) |-> !$past(|(FAULT_EVENTS & 8'hb0), 2))
			else $error("rail on after fault");
	a_cfg_on_write:
		assert property ($changed({BACKLIGHT_OVERVOLTAGE_LEVEL, BIAS_OPERATING_MODE}) |-> SDA_OE) else $error("cfg moved idle");
	a_ilim_on_write:
		assert property ($changed({INDUCTOR_RANGE_SELECT, BACKLIGHT_OVERCURRENT_LIMIT}) && !$past(SYS_RST, 2) |-> SDA_OE)
			else $error("limit moved idle");
	a_disch_on_write:
		assert property ($changed({POS_RAIL_DISCHARGE, NEG_RAIL_DISCHARGE}) && !$past(SYS_RST, 2) |-> SDA_OE)
			else $error("discharge moved idle");
	cover property ($rose(|LED_STRING_ON));
	cover property ($rose(POSITIVE_BIAS_OUTPUT));
	cover property ($rose(SDA_OE));
endmodule
bind bias_regs_top bias_port_chk u_chk (.CLK, .SYS_RST, .SCL_I, .SDA_OE, .FAULT_EVENTS, .LED_STRING_ON,
	.POSITIVE_BIAS_OUTPUT, .NEGATIVE_BIAS_OUTPUT, .POS_RAIL_DISCHARGE, .NEG_RAIL_DISCHARGE,
	.BIAS_OPERATING_MODE, .BACKLIGHT_OVERVOLTAGE_LEVEL, .BACKLIGHT_OVERCURRENT_LIMIT, .INDUCTOR_RANGE_SELECT);

// File: verification/i2c_host_model.sv
// i2c host model, 8 clk per scl half period
// assumes a pulled-up sda wire resolved by the bench
`timescale 1ns/1ns
module i2c_host #(
	parameter logic [6:0] ADDR = bias_pkg::DEV_ADDR_DEF
) (
	input  wire logic clk,
	input  wire logic sda,
	output logic      scl,
	output logic      pull
);
	import bias_pkg::*;
	int nak;
	initial begin
		scl = 1'b1;
		pull = 1'b0;
		nak = 0;
	end
	task automatic tk(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic put(input logic b);
		pull <= !b;
		tk(4);
		scl <= 1'b1;
		tk(8);
		scl <= 1'b0;
		tk(4);
	endtask
	task automatic get(output logic b);
		pull <= 1'b0;
		tk(4);
		scl <= 1'b1;
		tk(4);
		b = sda;
		tk(4);
		scl <= 1'b0;
		tk(4);
	endtask
	task automatic start();
		pull <= 1'b0;
		tk(4);
		scl <= 1'b1;
		tk(8);
		pull <= 1'b1;
		tk(8);
		scl <= 1'b0;
		tk(4);
	endtask
	task automatic stop();
		pull <= 1'b1;
		tk(4);
		scl <= 1'b1;
		tk(8);
		pull <= 1'b0;
		tk(8);
	endtask
	task automatic send(input logic [7:0] d);
		logic a;
		for (int i = 7; i >= 0; i--) put(d[i]);
		get(a);
		if (a !== 1'b0) nak++;
	endtask
	// address phase only, reports whether the target answered
	task automatic ping(input logic [6:0] a, output logic acked);
		logic b;
		start();
		for (int i = 6; i >= 0; i--) put(a[i]);
		put(1'b0);
		get(b);
		acked = !b;
		stop();
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d[$]);
		start();
		send({ADDR, 1'b0});
		send(a);
		foreach (d[i]) send(d[i]);
		stop();
	endtask
	task automatic rd(input logic [7:0] a, input int n, output logic [7:0] d[$]);
		logic [7:0] b;
		d = {};
		start();
		send({ADDR, 1'b0});
		send(a);
		start();
		send({ADDR, 1'b1});
		for (int i = 0; i < n; i++) begin
			for (int k = 7; k >= 0; k--) get(b[k]);
			put(i == n - 1);
			d.push_back(b);
		end
		stop();
	endtask
endmodule

// File: verification/tb.sv
// self-checking bench for the backlight/bias register bank
// assumes the host model drives the bus and the monitor is bound
`timescale 1ns/1ns
module tb;
	import bias_pkg::*;
	logic       clk, rst, pp, np, scl, pull, so, oe, po, no, pd, nd;
	logic [7:0] ev;
	logic [3:0] led;
	logic [2:0] md, ov;
	logic [1:0] oc, ind;
	logic [7:0] q[$];
	int         failures;
	int         num_checks;
	wire        sda = !(pull || (oe && !so));
	i2c_host u_host (.clk(clk), .sda(sda), .scl(scl), .pull(pull));
	bias_regs_top u_dut (.CLK(clk), .SYS_RST(rst), .SCL_I(scl), .SDA_I(sda), .SDA_O(so), .SDA_OE(oe),
		.POS_RAIL_ENABLE_PIN(pp), .NEG_RAIL_ENABLE_PIN(np), .FAULT_EVENTS(ev), .LED_STRING_ON(led),
		.POSITIVE_BIAS_OUTPUT(po), .NEGATIVE_BIAS_OUTPUT(no), .POS_RAIL_DISCHARGE(pd), .NEG_RAIL_DISCHARGE(nd),
		.BIAS_OPERATING_MODE(md), .BACKLIGHT_OVERVOLTAGE_LEVEL(ov), .BACKLIGHT_OVERCURRENT_LIMIT(oc),
		.INDUCTOR_RANGE_SELECT(ind));
	initial begin
		clk = 1'b0;
		forever #2 clk = !clk;
	end
	task automatic give_verdict();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic tk(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic t_defaults();
		logic [7:0] e[16];
		e = '{default: 8'h00};
		e[BLEN_OFS - OVP_OFS] = BLEN_RST;
		e[BIAS_OFS - OVP_OFS] = BIAS_RST;
		e[ILIM_OFS - OVP_OFS] = ILIM_RST;
		u_host.rd(OVP_OFS, 16, q);
		foreach (e[i]) chk(q[i], e[i]);
		chk(ind, ILIM_RST[IND_LSB +: IND_W]);
		chk(oc, ILIM_RST[OCP_LSB +: OCP_W]);
		chk({pd, nd}, BIAS_RST[4:3]);
		chk({led, po, no}, 8'h00);
	endtask
	task automatic t_config();
		u_host.wr(BLEN_OFS, {8'h13, 8'ha4});
		chk(led, 4'h3);
		chk({md, pd, nd, po, no}, 8'h52);
		u_host.wr(OVP_OFS, {8'he0});
		u_host.wr(ILIM_OFS, {8'h42});
		chk({ov, ind, oc}, 8'h7a);
		u_host.rd(BLEN_OFS, 2, q);
		chk(q[0], 8'h13);
		chk(q[1], 8'ha4);
		u_host.wr(BLEN_OFS, {8'h0f});
		chk(led, 4'h0);
	endtask
	task automatic t_pins();
		u_host.wr(BIAS_OFS, {8'h27});
		pp <= 1'b1;
		tk(4);
		chk({po, no}, 8'h02);
		pp <= 1'b0;
		np <= 1'b1;
		tk(4);
		chk({po, no}, 8'h01);
		u_host.wr(BIAS_OFS, {8'h24});
		chk({po, no}, 8'h02);
		np <= 1'b0;
		u_host.wr(BIAS_OFS, {8'h04});
		chk({po, md}, 8'h00);
	endtask
	task automatic t_faults();
		u_host.wr(BLEN_OFS, {8'h10});
		ev <= 8'hc0;
		tk(1);
		ev <= 8'h00;
		u_host.wr(BLEN_OFS, {8'h11});
		chk(led, 4'h0);
		u_host.rd(FLAG_OFS, 1, q);
		chk(q[0], 8'hc0);
		chk(led, 4'h1);
		u_host.rd(FLAG_OFS, 1, q);
		chk(q[0], 8'h00);
		ev <= 8'h40;
		tk(1);
		ev <= 8'h00;
		u_host.wr(BIAS_OFS, {8'h24});
		chk(po, 8'h01);
		ev <= 8'h20;
		tk(1);
		ev <= 8'h00;
		u_host.wr(BIAS_OFS, {8'h22});
		chk({po, no}, 8'h00);
		u_host.rd(FLAG_OFS, 1, q);
		chk(q[0], 8'h60);
		chk({po, no}, 8'h01);
	endtask
	task automatic t_address();
		logic ack;
		u_host.ping(DEV_ADDR_DEF ^ 7'h01, ack);
		chk(ack, 8'h00);
		u_host.ping(DEV_ADDR_DEF, ack);
		chk(ack, 8'h01);
	endtask
	initial begin
		#200000;
		failures++;
		give_verdict();
	end
	initial begin
		rst = 1'b1;
		pp = 1'b0;
		np = 1'b0;
		ev = 8'h00;
		failures = 0;
		num_checks = 0;
		tk(5);
		rst <= 1'b0;
		tk(2);
		t_defaults();
		t_address();
		t_config();
		t_pins();
		t_faults();
		u_host.wr(BLEN_OFS, {8'h80});
		t_defaults();
		chk(8'(u_host.nak), 8'h00);
		give_verdict();
	end
endmodule
